// file: verilog/acic_pkg.sv
package acic_pkg;
  localparam int NCH = 2;
  localparam int DW = 18;
  localparam int TCW = 13;
  localparam int LVW = 7;
  localparam int MAGW = 33;
  localparam int CNTW = 6;
  localparam int KW = 17;
  localparam int THRW = LVW + KW;
  // timing
  localparam int CLK_NS = 100;
  localparam int TC_STEP_NS = 10000;
  localparam int SAMPLE_NS = 10000;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;
  localparam int TC_PER_SAMPLE = TC_STEP_NS / SAMPLE_NS;
  localparam logic [TCW-1:0] TC_MAX = 13'h1900;
  localparam logic [LVW-1:0] LEVEL_MAX = 7'h64;
  localparam logic [TCW-1:0] TC_RESET = 13'h0000;
  localparam logic [LVW-1:0] LEVEL_RESET = 7'h00;
  // scaling, microvolts per count
  localparam int LEVEL_STEP_UV = 100000;
  localparam int IN1_STEP_UV = 359;
  localparam int IN2_STEP_UV = 5860;
  localparam int K_SHIFT = 8;
  localparam logic [KW-1:0] LVL_K [NCH] = '{
    KW'((LEVEL_STEP_UV * 256) / IN1_STEP_UV),
    KW'((LEVEL_STEP_UV * 256) / IN2_STEP_UV)};
  localparam logic signed [DW-1:0] OFF_MAX [NCH] = '{18'sh015CA, 18'sh00156};
  localparam logic signed [DW-1:0] OFF_RESET = 18'sh00000;
  localparam logic [CNTW-1:0] DIV_STEPS = 6'h21;
  typedef enum logic [1:0] {
    ACIC_IDLE = 2'b00,
    ACIC_DIV = 2'b01,
    ACIC_DONE = 2'b10
  } acic_state_type;
endpackage : acic_pkg

// file: verilog/acic_top.sv
`timescale 1ns/10ps
// What this block does
// - programmable first-order lag filter per input
// - alarm when compensated voltage exceeds level
// - zero overflow level disables the alarm
// - input two subtracts offset, 5.86 mV steps
// - auto adjust writes measured offset into setting
// - input one subtracts offset, 0.359 mV steps
module acic_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] input_one_sample_i,
  input wire logic signed [11:0] torque_command_input_i,
  input wire logic signed [13:0] input_one_offset_setting_i,
  input wire logic signed [9:0] input_two_offset_setting_i,
  input wire logic offset_write_i,
  input wire logic auto_offset_start_i,
  input wire logic [12:0] input_one_filter_time_constant_i,
  input wire logic [12:0] input_two_filter_time_constant_i,
  input wire logic [6:0] input_one_overflow_level_i,
  input wire logic [6:0] input_two_overflow_level_i,
  input wire logic alarm_clear_i,
  output logic signed [17:0] input_one_filtered_o,
  output logic signed [17:0] input_two_filtered_o,
  output logic filtered_valid_o,
  output logic input_one_alarm_o,
  output logic input_two_alarm_o,
  output logic signed [13:0] input_one_offset_o,
  output logic signed [9:0] input_two_offset_o,
  output logic auto_offset_busy_o
);
  localparam int DW = acic_pkg::DW;
  localparam int NCH = acic_pkg::NCH;
  localparam int MAGW = acic_pkg::MAGW;
  localparam int TCW = acic_pkg::TCW;
  localparam int LVW = acic_pkg::LVW;
  localparam int THRW = acic_pkg::THRW;
  localparam int CNTW = acic_pkg::CNTW;

  logic signed [DW-1:0] sample [NCH];
  logic signed [DW-1:0] set_off [NCH];
  logic [TCW-1:0] tc [NCH];
  logic [LVW-1:0] lvl [NCH];
  logic signed [DW-1:0] y_q [NCH];
  logic signed [DW-1:0] off_q [NCH];
  logic alarm_q [NCH];
  logic done [NCH];
  logic auto_pend_q;

  assign sample[0] = DW'(input_one_sample_i);
  assign sample[1] = DW'(torque_command_input_i);
  assign set_off[0] = DW'(input_one_offset_setting_i);
  assign set_off[1] = DW'(input_two_offset_setting_i);
  assign tc[0] = input_one_filter_time_constant_i;
  assign tc[1] = input_two_filter_time_constant_i;
  assign lvl[0] = input_one_overflow_level_i;
  assign lvl[1] = input_two_overflow_level_i;

  function automatic logic signed [DW-1:0] clamp_off(input logic signed [DW-1:0] v,
                                                      input logic signed [DW-1:0] lim);
    if (v > lim)
    begin
      clamp_off = lim;
    end
    else if (v < -lim)
    begin
      clamp_off = -lim;
    end
    else
    begin
      clamp_off = v;
    end
  endfunction : clamp_off

  // auto adjust samples the next conversion on both inputs (0 V applied by user)
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      auto_pend_q <= 1'b0;
    end
    else if (auto_offset_start_i)
    begin
      auto_pend_q <= 1'b1;
    end
    else if (sample_valid_i)
    begin
      auto_pend_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic signed [DW-1:0] comp_q;
      logic signed [DW-1:0] comp_d;
      logic [DW-1:0] mag_c;
      logic [THRW-1:0] thr_c;
      logic over_c;
      acic_pkg::acic_state_type st_q;
      logic [TCW:0] div_q;
      logic [MAGW-1:0] quo_q;
      logic [TCW:0] rem_q;
      logic [CNTW-1:0] cnt_q;
      logic neg_q;
      logic signed [MAGW-1:0] num_c;
      logic [TCW+1:0] rem_sh;
      logic signed [MAGW-1:0] num_q;

      assign comp_d = sample[g] - off_q[g];
      assign mag_c = comp_d[DW-1] ? DW'(-comp_d) : comp_d;
      assign thr_c = (THRW'(lvl[g]) * THRW'(acic_pkg::LVL_K[g])) >> acic_pkg::K_SHIFT;
      assign over_c = (lvl[g] != '0) && (THRW'(mag_c) > thr_c);

      // offset register: auto capture beats a manual write
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          off_q[g] <= acic_pkg::OFF_RESET;
        end
        else if (auto_pend_q && sample_valid_i)
        begin
          off_q[g] <= clamp_off(sample[g], acic_pkg::OFF_MAX[g]);
        end
        else if (offset_write_i)
        begin
          off_q[g] <= clamp_off(set_off[g], acic_pkg::OFF_MAX[g]);
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          comp_q <= '0;
        end
        else if (sample_valid_i)
        begin
          comp_q <= comp_d;
        end
      end

      // sticky alarm; a new overflow wins over a clear in the same cycle
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          alarm_q[g] <= 1'b0;
        end
        else if (lvl[g] == '0)
        begin
          alarm_q[g] <= 1'b0;
        end
        else if (sample_valid_i && over_c)
        begin
          alarm_q[g] <= 1'b1;
        end
        else if (alarm_clear_i)
        begin
          alarm_q[g] <= 1'b0;
        end
      end

      // y_new = (y*tc + x) / (tc + 1), rounded; tc = 0 gives y_new = x
      assign num_c = MAGW'(y_q[g] * $signed({1'b0, tc[g]}) * acic_pkg::TC_PER_SAMPLE)
                     + MAGW'(comp_d);
      assign rem_sh = {rem_q, quo_q[MAGW-1]};

      // serial divider: 34 cycles, well inside one sample period
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          st_q <= acic_pkg::ACIC_IDLE;
          div_q <= '0;
          quo_q <= '0;
          rem_q <= '0;
          cnt_q <= '0;
          neg_q <= 1'b0;
          num_q <= '0;
          y_q[g] <= '0;
        end
        else
        begin
          case (st_q)
            acic_pkg::ACIC_IDLE:
            begin
              if (sample_valid_i)
              begin
                div_q <= (TCW+1)'(tc[g] * acic_pkg::TC_PER_SAMPLE) + 1'b1;
                neg_q <= num_c[MAGW-1];
                num_q <= num_c;
                quo_q <= (num_c[MAGW-1] ? MAGW'(-num_c) : MAGW'(num_c))
                         + MAGW'(tc[g] >> 1);
                rem_q <= '0;
                cnt_q <= acic_pkg::DIV_STEPS;
                st_q <= acic_pkg::ACIC_DIV;
              end
            end
            acic_pkg::ACIC_DIV:
            begin
              if (rem_sh >= {1'b0, div_q})
              begin
                rem_q <= (TCW+1)'(rem_sh - {1'b0, div_q});
                quo_q <= {quo_q[MAGW-2:0], 1'b1};
              end
              else
              begin
                rem_q <= rem_sh[TCW:0];
                quo_q <= {quo_q[MAGW-2:0], 1'b0};
              end
              cnt_q <= cnt_q - 1'b1;
              if (cnt_q == 6'h01)
              begin
                st_q <= acic_pkg::ACIC_DONE;
              end
            end
            acic_pkg::ACIC_DONE:
            begin
              y_q[g] <= neg_q ? -DW'(quo_q) : DW'(quo_q);
              st_q <= acic_pkg::ACIC_IDLE;
            end
            default:
            begin
              st_q <= acic_pkg::ACIC_IDLE;
            end
          endcase
        end
      end
      assign done[g] = (st_q == acic_pkg::ACIC_DONE);

      sequence s_start;
        st_q == acic_pkg::ACIC_IDLE && sample_valid_i;
      endsequence
      sequence s_divide;
        (st_q == acic_pkg::ACIC_DIV) [*8] ##1 (st_q == acic_pkg::ACIC_DIV) [*8]
        ##1 (st_q == acic_pkg::ACIC_DIV) [*8] ##1 (st_q == acic_pkg::ACIC_DIV) [*8]
        ##1 (st_q == acic_pkg::ACIC_DIV) ##1 (st_q == acic_pkg::ACIC_DONE);
      endsequence

      a_filter_latency: assert property (@(posedge clk_i) disable iff (srst_i)
        s_start |=> s_divide)
        else $error("filter update latency wrong");
      a_filter_pass: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_start ##1 (div_q == 14'h0001)) |-> ##34 (y_q[g] == DW'(num_q)))
        else $error("zero time constant did not pass input");
      a_filter_lag: assert property (@(posedge clk_i) disable iff (srst_i)
        (done[g] && div_q > 14'h0001 && y_q[g] < comp_q) |=>
        (y_q[g] <= comp_q && y_q[g] >= $past(y_q[g])))
        else $error("filter overshot its input");
      a_comp_sub: assert property (@(posedge clk_i) disable iff (srst_i)
        sample_valid_i |=> comp_q == $past(sample[g]) - $past(off_q[g]))
        else $error("offset compensation wrong");
      a_alarm_raise: assert property (@(posedge clk_i) disable iff (srst_i)
        (sample_valid_i && over_c && lvl[g] != '0) ##1 (lvl[g] != '0) |-> alarm_q[g])
        else $error("overflow did not raise alarm");
      a_alarm_disabled: assert property (@(posedge clk_i) disable iff (srst_i)
        (lvl[g] == '0) |=> !alarm_q[g])
        else $error("alarm raised with level zero");
      a_offset_auto: assert property (@(posedge clk_i) disable iff (srst_i)
        (auto_pend_q && sample_valid_i) |=>
        off_q[g] == clamp_off($past(sample[g]), acic_pkg::OFF_MAX[g]))
        else $error("auto offset not stored");
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      filtered_valid_o <= 1'b0;
    end
    else
    begin
      filtered_valid_o <= done[0];
    end
  end

  assign input_one_filtered_o = y_q[0];
  assign input_two_filtered_o = y_q[1];
  assign input_one_alarm_o = alarm_q[0];
  assign input_two_alarm_o = alarm_q[1];
  assign input_one_offset_o = off_q[0][13:0];
  assign input_two_offset_o = off_q[1][9:0];
  assign auto_offset_busy_o = auto_pend_q;
endmodule : acic_top

// file: dv/acic_adc_model.sv
`timescale 1ns/10ps
module acic_adc_model (
  input wire logic clk_i,
  output logic sample_valid_o,
  output logic signed [15:0] one_o,
  output logic signed [11:0] two_o
);
  initial
  begin
    sample_valid_o = 1'b0;
    one_o = 16'h0000;
    two_o = 12'h000;
  end
  // data scrambled outside the strobe, so stale values cannot pass
  task convert(input logic signed [15:0] a, input logic signed [11:0] b);
    @(negedge clk_i);
    sample_valid_o = 1'b1;
    one_o = a;
    two_o = b;
    @(negedge clk_i);
    sample_valid_o = 1'b0;
    one_o = ~a;
    two_o = ~b;
  endtask : convert
endmodule : acic_adc_model

// file: dv/analog_command_input_conditioning_test.sv
`timescale 1ns/10ps
module analog_command_input_conditioning_test;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sv;
  logic signed [15:0] s1;
  logic signed [11:0] s2;
  logic signed [13:0] off1 = 14'h0000;
  logic signed [9:0] off2 = 10'h000;
  logic wr = 1'b0;
  logic auto = 1'b0;
  logic [12:0] tc = 13'h0000;
  logic [6:0] lv = 7'h00;
  logic clr = 1'b0;
  logic signed [17:0] y1;
  logic signed [17:0] y2;
  logic fv;
  logic al1;
  logic al2;
  logic busy;
  logic signed [13:0] o1;
  logic signed [9:0] o2;
  int fail_count = 0;
  int total_checks = 0;

  always #50 clk_i = ~clk_i;

  acic_adc_model u_acic_adc_model (.clk_i(clk_i), .sample_valid_o(sv), .one_o(s1), .two_o(s2));

  acic_top u_acic_top (
    .clk_i(clk_i), .srst_i(srst_i), .sample_valid_i(sv),
    .input_one_sample_i(s1), .torque_command_input_i(s2),
    .input_one_offset_setting_i(off1), .input_two_offset_setting_i(off2),
    .offset_write_i(wr), .auto_offset_start_i(auto),
    .input_one_filter_time_constant_i(tc), .input_two_filter_time_constant_i(tc),
    .input_one_overflow_level_i(lv), .input_two_overflow_level_i(lv),
    .alarm_clear_i(clr), .input_one_filtered_o(y1), .input_two_filtered_o(y2),
    .filtered_valid_o(fv), .input_one_alarm_o(al1), .input_two_alarm_o(al2),
    .input_one_offset_o(o1), .input_two_offset_o(o2), .auto_offset_busy_o(busy)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // spacing kept well above the 35-cycle minimum
  task sample(input logic signed [15:0] a, input logic signed [11:0] b);
    int n;
    n = 0;
    u_acic_adc_model.convert(a, b);
    while (fv !== 1'b1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    check(fv, 32'h1);
    repeat (70) @(negedge clk_i);
  endtask : sample

  task test_pass;
    off1 = 14'h000A;
    off2 = 10'h3FB;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
    sample(16'h03E8, 12'h064);
    check(o1, 32'hA);
    check(o2, 32'hFFFFFFFB);
    check(y1, 32'h3DE);
    check(y2, 32'h69);
    check({al2, al1}, 32'h0);
    $display("test passthrough done");
  endtask : test_pass

  task test_filter;
    tc = 13'h0003;
    sample(16'h019A, 12'h05F);
    check(y1, 32'h34A);
    check(y2, 32'h68);
    sample(16'h03F2, 12'h06E);
    check(y1, 32'h371);
    check(y2, 32'h6B);
    tc = 13'h0000;
    $display("test filter done");
  endtask : test_filter

  task test_alarm;
    lv = 7'h01;
    sample(16'h0120, 12'h00C);
    check({al2, al1}, 32'h0);
    sample(16'h0120, 12'h00D);
    check({al2, al1}, 32'h2);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    @(negedge clk_i);
    check(al2, 32'h0);
    $display("test alarm done");
  endtask : test_alarm

  task test_auto;
    auto = 1'b1;
    @(negedge clk_i);
    auto = 1'b0;
    check(busy, 32'h1);
    sample(16'h0032, 12'hFF9);
    check(o1, 32'h32);
    check(o2, 32'hFFFFFFF9);
    check(busy, 32'h0);
    sample(16'h003C, 12'hFF9);
    check(y1, 32'hA);
    check(y2, 32'h0);
    $display("test auto offset done");
  endtask : test_auto

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    test_pass();
    test_filter();
    test_alarm();
    test_auto();
    give_verdict();
  end

  // about 7 samples of 110 cycles each are expected
  initial
  begin
    repeat (5000) @(negedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule : analog_command_input_conditioning_test
